// >>> hdl/scan_tap_pkg.sv
// Shared types and constants for the memory test access port
package scan_tap_pkg;

  // Pins from the board scan controller, all asynchronous to core_clk_in
  typedef struct packed {
    logic tck;          // Test clock level
    logic tms;          // Mode select level
    logic tms_undriven; // High when nobody drives mode select
    logic tdi;          // Serial data in level
    logic tdi_undriven; // High when nobody drives serial data in
  } scan_pins_t;

  localparam int PIN_W = $bits(scan_pins_t);

  // Controller states, sixteen in all
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Which serial register sits between data in and data out
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDENT, SEL_BOUNDARY
  } dr_sel_t;

  // Instruction codes
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLEZ = 3'h2;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h3;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
  // Fixed pattern loaded into the instruction shifter at capture
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

  // Register lengths and reset values
  localparam int BOUNDARY_LEN = 77;
  localparam int IDENT_LEN = 32;
  localparam int TLR_TMS_COUNT = 5;
  localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage

// >>> hdl/scan_pin_sync.sv
// Three-stage pin synchroniser that passes a level once stages two and three agree
module scan_pin_sync
  import scan_tap_pkg::*;
#(
  parameter int W = PIN_W
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  // Whole state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by s2
    logic [W-1:0] s2;  // Second stage
    logic [W-1:0] s3;  // Third stage
    logic [W-1:0] q;   // Accepted level
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Shift the stages and accept bits where stage two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  // Register the state
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.q;

endmodule

// >>> hdl/sram_boundary_scan_tap.sv
// Test access port of the synchronous memory: controller, instructions, scan registers
//
// Summary of operation
// - Sample capture loads memory inputs into boundary
// - Sample in shift-DR shifts boundary register
// - Capturing changing inputs is harmless, maybe unrepeatable
// - High-impedance sample forces memory outputs off
// - High-impedance sample shifts boundary register
// - Three-bit decode; codes 5..7 mean bypass
// - Extest and high-impedance sample tristate outputs
// - Undriven mode select and data read one
// - Five mode-select highs or power-up reset
// - Identification loaded at power-up and reset state
// - Extest acts as sample with outputs off
// - Data out changes on test clock fall
module sram_boundary_scan_tap
  import scan_tap_pkg::*;
#(
  parameter int BSR_LEN = BOUNDARY_LEN,
  parameter logic [IDENT_LEN-1:0] IDENT_CODE = 32'h5a5a_a5a5 | 32'h0000_0001 // Arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire scan_pins_t scan_pins_in,
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic mem_out_hiz_out
);

  // Whole state of the port
  typedef struct packed {
    tap_state_t state;          // Controller state
    logic [IR_W-1:0] ir;        // Active instruction
    logic [IR_W-1:0] ir_shift;  // Instruction shifter
    logic [BSR_LEN-1:0] bsr;    // Boundary register, bit 0 nearest data out
    logic [BSR_LEN-1:0] ring1;  // Ring capture stage one
    logic [BSR_LEN-1:0] ring2;  // Ring capture stage two
    logic [BSR_LEN-1:0] ring3;  // Ring capture stage three
    logic [BSR_LEN-1:0] ring_q; // Ring level accepted once stages two and three agree
    logic [2:0] tms_hi;         // Consecutive rises with mode select high
    logic [IDENT_LEN-1:0] idr;  // Identification register
    logic byp;                  // Bypass bit
    logic tck_prev;             // Accepted test clock one cycle ago
    logic tdo;                  // Serial output
    logic tdo_oe_n;             // Output enable, low while driving
    logic hiz;                  // Memory outputs forced off
  } tap_reg_t;

  tap_reg_t st;
  tap_reg_t next_st;
  scan_pins_t pins;   // Synchronised pins
  logic tck_rise;     // Rising test clock seen this cycle
  logic tck_fall;     // Falling test clock seen this cycle
  logic tms_eff;      // Mode select as seen by the controller
  logic tdi_eff;      // Serial input as seen by the registers
  dr_sel_t sel;       // Register picked by the active instruction

  // Instruction to register selection
  // three-bit instruction decode
  function automatic dr_sel_t decode_sel(input logic [IR_W-1:0] op);
    unique case (op)
      OP_EXTEST, OP_SAMPLEZ, OP_SAMPLE: decode_sel = SEL_BOUNDARY;
      OP_IDCODE: decode_sel = SEL_IDENT;
      default: decode_sel = SEL_BYPASS;
    endcase
  endfunction

  // Instructions that force memory outputs off
  function automatic logic decode_hiz(input logic [IR_W-1:0] op);
    decode_hiz = (op == OP_EXTEST) || (op == OP_SAMPLEZ);
  endfunction

  // Controller transition on one rising test clock edge
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    unique case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction

  // Pins into the core clock domain
  scan_pin_sync #(.W(PIN_W)) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(scan_pins_in),
    .pin_out(pins)
  );

  // Edge detection and effective pin levels
  always_comb begin
    tck_rise = pins.tck && !st.tck_prev;
    tck_fall = !pins.tck && st.tck_prev;
    tms_eff = pins.tms | pins.tms_undriven;
    tdi_eff = pins.tdi | pins.tdi_undriven;
    sel = decode_sel(st.ir);
  end

  // Next state of the whole port
  always_comb begin
    next_st = st;
    next_st.tck_prev = pins.tck;
    // ring passes three stages before capture
    next_st.ring1 = ring_in;
    next_st.ring2 = st.ring1;
    next_st.ring3 = st.ring2;
    // Accept a ring bit only when stages two and three agree
    for (int i = 0; i < BSR_LEN; i++) begin
      if (st.ring2[i] == st.ring3[i]) begin
        next_st.ring_q[i] = st.ring3[i];
      end
    end
    // Rising edge: controller step and register actions
    if (tck_rise) begin
      next_st.state = tap_next(st.state, tms_eff);
      if (!tms_eff) begin
        next_st.tms_hi = SYNC_RESET;
      end else if (st.tms_hi != 3'(TLR_TMS_COUNT)) begin
        next_st.tms_hi = st.tms_hi + 3'h1;
      end
      unique case (st.state)
        ST_RESET: begin
          next_st.ir = OP_IDCODE;
        end
        ST_CAP_DR: begin
          next_st.bsr = st.ring_q;
          next_st.idr = IDENT_CODE;
          next_st.byp = 1'b0;
        end
        ST_SHIFT_DR: begin
          unique case (sel)
            // boundary between data in and out
            SEL_BOUNDARY: next_st.bsr = {tdi_eff, st.bsr[BSR_LEN-1:1]};
            SEL_IDENT: next_st.idr = {tdi_eff, st.idr[IDENT_LEN-1:1]};
            SEL_BYPASS: next_st.byp = tdi_eff;
          endcase
        end
        ST_CAP_IR: begin
          next_st.ir_shift = IR_CAPTURE_VAL;
        end
        ST_SHIFT_IR: begin
          next_st.ir_shift = {tdi_eff, st.ir_shift[IR_W-1:1]};
        end
        ST_UPD_IR: begin
          next_st.ir = st.ir_shift;
        end
        default: begin
        end
      endcase
      if (next_st.state == ST_RESET) begin
        next_st.ir = OP_IDCODE;
      end
    end
    if (tck_fall) begin
      next_st.tdo_oe_n = !(st.state == ST_SHIFT_DR || st.state == ST_SHIFT_IR);
      if (st.state == ST_SHIFT_IR) begin
        next_st.tdo = st.ir_shift[0];
      end else begin
        unique case (sel)
          SEL_BOUNDARY: next_st.tdo = st.bsr[0];
          SEL_IDENT: next_st.tdo = st.idr[0];
          SEL_BYPASS: next_st.tdo = st.byp;
        endcase
      end
    end
    next_st.hiz = decode_hiz(next_st.ir);
  end

  // Register the state; reset stands for power-up
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
      st.state <= ST_RESET;
      st.ir <= OP_IDCODE;
      st.ir_shift <= IR_CAPTURE_VAL;
      st.tdo_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign tdo_out = st.tdo;
  assign tdo_oe_n_out = st.tdo_oe_n;
  assign mem_out_hiz_out = st.hiz;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_five_high_reset: assert property (st.tms_hi == 3'(TLR_TMS_COUNT) |-> st.state == ST_RESET)
    else $error("Five mode-select highs did not reach reset state");

  a_reset_holds_id: assert property (st.state == ST_RESET |-> st.ir == OP_IDCODE)
    else $error("Reset state without identification instruction");

  // outputs off for the forcing codes
  a_hiz_follows_ir: assert property (
    (st.ir == OP_EXTEST || st.ir == OP_SAMPLEZ) |-> mem_out_hiz_out)
    else $error("Memory outputs not forced off");

  // outputs on for the other codes
  a_hiz_clear_other: assert property (
    (st.ir != OP_EXTEST && st.ir != OP_SAMPLEZ) |-> !mem_out_hiz_out)
    else $error("Memory outputs forced off for a plain code");

  a_decode_upper: assert property (st.ir[2] && st.ir[1:0] != 2'h0 |-> sel == SEL_BYPASS)
    else $error("Upper code not decoded as bypass");

  a_capture_ring: assert property (
    tck_rise && st.state == ST_CAP_DR && sel == SEL_BOUNDARY |=> st.bsr == $past(st.ring_q))
    else $error("Boundary capture lost ring values");

  a_shift_bsr: assert property (tck_rise && st.state == ST_SHIFT_DR && sel == SEL_BOUNDARY
    |=> st.bsr == {$past(tdi_eff), $past(st.bsr[BSR_LEN-1:1])})
    else $error("Boundary register did not shift");

  // data out presents nearest bit after fall
  a_tdo_on_fall: assert property (tck_fall && st.state == ST_SHIFT_DR && sel == SEL_BOUNDARY
    |=> tdo_out == $past(st.bsr[0]) && !tdo_oe_n_out)
    else $error("Data out wrong after falling edge");

  a_tdo_release: assert property (tck_fall && st.state != ST_SHIFT_DR
    && st.state != ST_SHIFT_IR |=> tdo_oe_n_out [*2])
    else $error("Data out driven outside shift");

endmodule

// >>> testbench/scan_ctrl_model.sv
// Board scan controller model driving the test pins
module scan_ctrl_model
  import scan_tap_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in,
  output scan_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Parked: clock low, lines released at the level opposite to read-as-one
  initial pins_out = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  // One 80 ns test clock period: 10 core cycles low, 10 high
  // Undriven bits: 1 mode select, 0 data in; a released line shows the inverse level
  // levels held over rise
  task automatic step(input logic tms, input logic tdi, input logic [1:0] undrv,
                      output logic tdo, output logic oe_n);
    @(posedge core_clk_in);
    pins_out.tck <= 1'b0;
    pins_out.tms <= undrv[1] ? ~tms : tms;
    pins_out.tms_undriven <= undrv[1];
    pins_out.tdi <= undrv[0] ? ~tdi : tdi;
    pins_out.tdi_undriven <= undrv[0];
    repeat (10) @(posedge core_clk_in);
    tdo = tdo_in;
    oe_n = tdo_oe_n_in;
    pins_out.tck <= 1'b1;
    repeat (9) @(posedge core_clk_in);
  endtask

  task automatic park();
    @(posedge core_clk_in);
    pins_out.tck <= 1'b0;
    pins_out.tms <= 1'b0;
    pins_out.tms_undriven <= 1'b1;
    pins_out.tdi <= 1'b0;
    pins_out.tdi_undriven <= 1'b1;
  endtask
endmodule

// >>> testbench/sram_boundary_scan_tap_tb_top.sv
// Testbench for the memory test access port
module sram_boundary_scan_tap_tb_top
  import scan_tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BL = 8; // Short boundary register
  localparam logic [31:0] ID = 32'h3c96_0f2b; // Arbitrary value, bit 0 set
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  scan_pins_t pins;
  logic [BL-1:0] ring = '0;
  logic tdo, tdo_oe_n, hiz;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h2;
  logic tdi_free = 1'b0; // Leave data in undriven during scanned bits

  initial forever #2 core_clk = ~core_clk;

  sram_boundary_scan_tap #(.BSR_LEN(BL), .IDENT_CODE(ID)) sram_boundary_scan_tap_i (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst), .scan_pins_in(pins), .ring_in(ring),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .mem_out_hiz_out(hiz));
  scan_ctrl_model scan_ctrl_model_i (.core_clk_in(core_clk), .tdo_in(tdo),
    .tdo_oe_n_in(tdo_oe_n), .pins_out(pins));

  // Xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected shifted data for an instruction
  function automatic logic [63:0] exp_dr(logic [2:0] op, logic [BL-1:0] r, logic [63:0] d);
    case (op)
      OP_EXTEST, OP_SAMPLEZ, OP_SAMPLE: return 64'(r);
      OP_IDCODE: return 64'(ID);
      default: return {d[62:0], 1'b0};
    endcase
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic ctrl(input logic tms);
    logic t, oe;
    scan_ctrl_model_i.step(tms, 1'(xs()), 2'b00, t, oe);
  endtask

  // Idle to shift state, n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic t, oe;
    dout = '0;
    ctrl(1'b1);
    if (ir) ctrl(1'b1);
    ctrl(1'b0);
    ctrl(1'b0);
    for (int k = 0; k < n; k++) begin
      scan_ctrl_model_i.step(k == n - 1, din[k], {1'b0, tdi_free}, t, oe);
      // memory inputs keep moving after capture
      if (k == 1) ring <= ~ring;
      dout[k] = t;
      chk(oe, 1'b0, "tdo enable");
    end
    ctrl(1'b1);
    ctrl(1'b0);
    chk(tdo_oe_n, 1'b1, "tdo released");
    scan_ctrl_model_i.park();
  endtask

  initial begin
    logic [63:0] d, q, m;
    logic [2:0] op;
    logic [BL-1:0] r;
    logic t, oe;
    int n;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    ctrl(1'b0);
    chk(hiz, 1'b0, "hiz after reset");
    scan(1'b0, 32, 64'h0, q);
    chk(q, 64'(ID), "ident after reset");
    // All eight codes, then all-zeros again
    for (int i = 0; i < 9; i++) begin
      op = (i == 8) ? OP_EXTEST : 3'(i);
      scan(1'b1, 3, 64'(op), q);
      chk(q, 64'(IR_CAPTURE_VAL), "ir capture");
      chk(hiz, op == OP_EXTEST || op == OP_SAMPLEZ, "hiz");
      r = BL'(xs());
      ring <= r;
      d = {xs(), xs()};
      n = (op == OP_IDCODE) ? 32 : BL;
      m = (64'h1 << n) - 64'h1;
      scan(1'b0, n, d, q);
      chk(q & m, exp_dr(op, r, d) & m, "data scan");
    end
    // Undriven mode select from shift-DR: five highs reach reset
    ctrl(1'b1);
    ctrl(1'b0);
    ctrl(1'b0);
    repeat (5) scan_ctrl_model_i.step(1'b1, 1'b0, 2'b10, t, oe);
    chk(hiz, 1'b0, "hiz after tms reset");
    ctrl(1'b0);
    scan(1'b0, 32, 64'h0, q);
    chk(q, 64'(ID), "ident after tms reset");
    // Undriven data in: instruction reads 111, an upper bypass code, and shifts ones
    tdi_free = 1'b1;
    scan(1'b1, 3, 64'(OP_SAMPLE), q);
    chk(q, 64'(IR_CAPTURE_VAL), "ir capture undriven");
    chk(hiz, 1'b0, "hiz upper code");
    m = (64'h1 << BL) - 64'h1;
    scan(1'b0, BL, 64'h0, q);
    chk(q & m, exp_dr(3'h7, r, ~64'h0) & m, "undriven data in");
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    end_sim();
  end
endmodule
